// [src/homing_pkg.sv]
// Constants and types shared by the stepper homing sequencer.
`default_nettype none
package homing_pkg;
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned DWELL_TIME_MS = 2000;
  localparam int unsigned RAMP_TICK_US  = 1000;

  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CMD     = 8'h04;
  localparam logic [7:0] OFS_GATE    = 8'h08;
  localparam logic [7:0] OFS_START   = 8'h0c;
  localparam logic [7:0] OFS_PROG    = 8'h10;
  localparam logic [7:0] OFS_ACCEL   = 8'h14;
  localparam logic [7:0] OFS_PRE_MOT = 8'h18;
  localparam logic [7:0] OFS_PRE_ENC = 8'h1c;
  localparam logic [7:0] OFS_STEPS   = 8'h20;
  localparam logic [7:0] OFS_COUNTS  = 8'h24;
  localparam logic [7:0] OFS_MOT_POS = 8'h28;
  localparam logic [7:0] OFS_ENC_POS = 8'h2c;
  localparam logic [7:0] OFS_STATUS  = 8'h30;
  localparam logic [7:0] OFS_STATE   = 8'h34;

  localparam int CTRL_GATE_EN  = 0;
  localparam int CTRL_HOME_CFG = 1;
  localparam int CTRL_CWL_CFG  = 2;
  localparam int CTRL_CCWL_CFG = 3;
  localparam int CTRL_ENC_EN   = 4;
  localparam int CTRL_W        = 5;

  localparam int CMD_CW       = 0;
  localparam int CMD_CCW      = 1;
  localparam int CMD_HOLD     = 2;
  localparam int CMD_PRE_MOT  = 3;
  localparam int CMD_PRE_ENC  = 4;
  localparam int CMD_PRE_FENC = 5;
  localparam int CMD_MOVE_ABS = 6;
  localparam int CMD_MOVE_REL = 7;
  localparam int CMD_CLEAR    = 8;

  localparam int ST_BUSY      = 0;
  localparam int ST_HOMED     = 1;
  localparam int ST_INVALID   = 2;
  localparam int ST_NO_HOME   = 3;
  localparam int ST_PRE_ERR   = 4;
  localparam int ST_ABS_REF   = 5;

  localparam int SPEED_W = 24;
  localparam logic [CTRL_W-1:0]  CTRL_RESET   = 5'h00;
  localparam logic [SPEED_W-1:0] START_RESET  = 24'h0003e8;
  localparam logic [SPEED_W-1:0] PROG_RESET   = 24'h001388;
  localparam logic [SPEED_W-1:0] ACCEL_RESET  = 24'h000064;
  localparam logic [15:0]        STEPS_RESET  = 16'h0190;
  localparam logic [15:0]        COUNTS_RESET = 16'h1000;
  localparam logic signed [31:0] PRESET_LIMIT = 32'sh007fffff;

  typedef enum logic [8:0] {
    S_IDLE   = 9'h001,
    S_RUN1   = 9'h002,
    S_DEC1   = 9'h004,
    S_DWELL1 = 9'h008,
    S_RUN2   = 9'h010,
    S_DEC2   = 9'h020,
    S_DWELL2 = 9'h040,
    S_CREEP  = 9'h080,
    S_HOLD   = 9'h100
  } state_t;
endpackage
`default_nettype wire

// [src/stepper_homing_sequencer.sv]
// Homing sequencer, position registers and step generator with an APB register file.
//
// What this block does
// - Completed home search zeroes motor position.
// - Completed search zeroes encoder if enabled.
// - Separate presets, limited to plus/minus 8388607.
// - Motor preset from encoder scaled steps/counts.
// - Only absolute moves need an established home.
// - Clockwise search ends clockwise at start speed.
// - Counter-clockwise search mirrors every direction.
// - Gated: sensor ignored until gate rises.
// - Gate disabled at reset, enabled by configuration.
// - Search refused without configured home input.
// - Unconfigured limits give no overtravel protection.
// - Run to sensor, decelerate, stop, dwell.
// - Reverse until sensor inactive, stop, dwell.
// - Creep back at start speed to edge.
// - Ungated: sensor active at start skips to reverse.
// - Gated: decelerate on gate edge, stop on sensor.
// - Gated speed never falls below start speed.
// - Gate bit acts on its rising edge.
// - Forward limit: stop, dwell, reverse, creep.
// - Opposite limit: stop, raise invalid home fault.
// - Forward limit active at start: reverse first.
// - Hold aborts search with deceleration, no resume.
`default_nettype none
module stepper_homing_sequencer #(
  parameter int unsigned RAMP_TICK_CYCLES =
    homing_pkg::CLK_HZ / 1_000_000 * homing_pkg::RAMP_TICK_US,
  parameter int unsigned DWELL_CYCLES =
    homing_pkg::CLK_HZ / 1000 * homing_pkg::DWELL_TIME_MS
) (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        HOME_IN,
  input  wire logic        LIMIT_CW_IN,
  input  wire logic        LIMIT_CCW_IN,
  input  wire logic        ENC_UP,
  input  wire logic        ENC_DOWN,
  output var  logic        STEP_OUT,
  output var  logic        DIR_CW,
  output var  logic        MOVE_GO,
  output var  logic        MOVE_ABSOLUTE
);
  localparam int SW = homing_pkg::SPEED_W;

  homing_pkg::state_t  state;
  logic [homing_pkg::CTRL_W-1:0] ctrl;
  logic                gate;
  logic                gate_q;
  logic [SW-1:0]       start_speed;
  logic [SW-1:0]       prog_speed;
  logic [SW-1:0]       accel;
  logic signed [31:0]  pre_mot;
  logic signed [31:0]  pre_enc;
  logic [15:0]         steps_per_turn;
  logic [15:0]         counts_per_turn;
  logic signed [31:0]  motor_pos;
  logic signed [31:0]  enc_pos;
  logic [5:0]          status;
  logic                dir_search;
  logic                hunting;
  logic                home_q;
  logic [31:0]         dwell_cnt;
  logic [31:0]         tick_cnt;
  logic                tick;
  logic [SW-1:0]       cur_speed;
  logic [SW-1:0]       target;
  logic [31:0]         step_acc;
  logic [31:0]         acc_sum;
  logic [31:0]         next_rdata;
  logic                mapped;
  logic                wr;
  logic                wr_cmd;
  logic [31:0]         cmd;
  logic                home_act;
  logic                home_rise;
  logic                lim_cw;
  logic                lim_ccw;
  logic                lim_fwd;
  logic                lim_back;
  logic                gate_rise;
  logic                moving;
  logic                dwelling;
  logic                busy;
  logic                at_floor;
  logic                dwell_done;
  logic                start_req;
  logic                hold_req;
  logic                fault_now;
  logic                finish;
  logic                pre_mot_ok;
  logic                pre_enc_ok;
  logic                pre_fenc_ok;
  logic                pre_refused;
  logic signed [47:0]  enc_prod;
  logic signed [47:0]  scaled;

  function automatic logic in_range(input logic signed [31:0] v);
    in_range = (v <= homing_pkg::PRESET_LIMIT) && (v >= -homing_pkg::PRESET_LIMIT);
  endfunction

  function automatic logic [SW-1:0] ramp(input logic [SW-1:0] cur,
                                        input logic [SW-1:0] tgt,
                                        input logic [SW-1:0] step);
    if (cur < tgt)
    begin
      ramp = (tgt - cur <= step) ? tgt : cur + step;
    end
    else
    begin
      ramp = (cur - tgt <= step) ? tgt : cur - step;
    end
  endfunction

  // Zero-wait slave: every access completes in its first access cycle.
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign wr      = PSEL & PENABLE & PWRITE & mapped;
  assign wr_cmd  = wr & (PADDR == homing_pkg::OFS_CMD);
  assign cmd     = wr_cmd ? PWDATA : 32'h0;

  assign home_act  = ctrl[homing_pkg::CTRL_HOME_CFG] & HOME_IN;
  assign home_rise = home_act & ~home_q;
  assign lim_cw    = ctrl[homing_pkg::CTRL_CWL_CFG] & LIMIT_CW_IN;
  assign lim_ccw   = ctrl[homing_pkg::CTRL_CCWL_CFG] & LIMIT_CCW_IN;
  assign lim_fwd   = dir_search ? lim_cw : lim_ccw;
  assign lim_back  = dir_search ? lim_ccw : lim_cw;
  assign gate_rise = gate & ~gate_q;

  assign moving   = state inside {homing_pkg::S_RUN1, homing_pkg::S_DEC1,
                                  homing_pkg::S_RUN2, homing_pkg::S_DEC2,
                                  homing_pkg::S_CREEP, homing_pkg::S_HOLD};
  assign dwelling = state inside {homing_pkg::S_DWELL1, homing_pkg::S_DWELL2};
  assign busy     = state != homing_pkg::S_IDLE;
  assign at_floor = (cur_speed != '0) && (cur_speed <= start_speed);
  assign dwell_done = dwell_cnt == DWELL_CYCLES - 1;

  assign start_req = cmd[homing_pkg::CMD_CW] | cmd[homing_pkg::CMD_CCW];
  assign hold_req  = cmd[homing_pkg::CMD_HOLD];
  assign fault_now = moving & lim_back;

  // Gated searches end in the run phase unless a forward limit sends them to the creep; plain searches end in the creep.
  assign finish = (state == homing_pkg::S_CREEP && home_rise) ||
                  (state == homing_pkg::S_RUN1 && hunting && home_rise);

  assign pre_mot_ok  = ~busy & cmd[homing_pkg::CMD_PRE_MOT] & in_range(pre_mot);
  assign pre_enc_ok  = ~busy & cmd[homing_pkg::CMD_PRE_ENC] & in_range(pre_enc);
  assign pre_fenc_ok = ~busy & cmd[homing_pkg::CMD_PRE_FENC] & (counts_per_turn != 16'h0);
  assign pre_refused = (cmd[homing_pkg::CMD_PRE_MOT] & ~pre_mot_ok) |
                       (cmd[homing_pkg::CMD_PRE_ENC] & ~pre_enc_ok) |
                       (cmd[homing_pkg::CMD_PRE_FENC] & ~pre_fenc_ok);

  assign enc_prod = 48'(enc_pos) * $signed({32'h0, steps_per_turn});
  assign scaled   = enc_prod / $signed({32'h0, counts_per_turn});

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ctrl            <= homing_pkg::CTRL_RESET;
      gate            <= 1'b0;
      start_speed     <= homing_pkg::START_RESET;
      prog_speed      <= homing_pkg::PROG_RESET;
      accel           <= homing_pkg::ACCEL_RESET;
      pre_mot         <= '0;
      pre_enc         <= '0;
      steps_per_turn  <= homing_pkg::STEPS_RESET;
      counts_per_turn <= homing_pkg::COUNTS_RESET;
    end
    else if (wr)
    begin
      case (PADDR)
        homing_pkg::OFS_CTRL:    ctrl <= PWDATA[homing_pkg::CTRL_W-1:0];
        homing_pkg::OFS_GATE:    gate <= PWDATA[0];
        homing_pkg::OFS_START:   start_speed <= PWDATA[SW-1:0];
        homing_pkg::OFS_PROG:    prog_speed <= PWDATA[SW-1:0];
        homing_pkg::OFS_ACCEL:   accel <= PWDATA[SW-1:0];
        homing_pkg::OFS_PRE_MOT: pre_mot <= PWDATA;
        homing_pkg::OFS_PRE_ENC: pre_enc <= PWDATA;
        homing_pkg::OFS_STEPS:   steps_per_turn <= PWDATA[15:0];
        homing_pkg::OFS_COUNTS:  counts_per_turn <= PWDATA[15:0];
        default:                 ;
      endcase
    end
  end

  always_comb
  begin
    mapped     = 1'b1;
    next_rdata = 32'h0;
    case (PADDR)
      homing_pkg::OFS_CTRL:    next_rdata = {27'h0, ctrl};
      homing_pkg::OFS_CMD:     next_rdata = 32'h0;
      homing_pkg::OFS_GATE:    next_rdata = {31'h0, gate};
      homing_pkg::OFS_START:   next_rdata = {8'h0, start_speed};
      homing_pkg::OFS_PROG:    next_rdata = {8'h0, prog_speed};
      homing_pkg::OFS_ACCEL:   next_rdata = {8'h0, accel};
      homing_pkg::OFS_PRE_MOT: next_rdata = pre_mot;
      homing_pkg::OFS_PRE_ENC: next_rdata = pre_enc;
      homing_pkg::OFS_STEPS:   next_rdata = {16'h0, steps_per_turn};
      homing_pkg::OFS_COUNTS:  next_rdata = {16'h0, counts_per_turn};
      homing_pkg::OFS_MOT_POS: next_rdata = motor_pos;
      homing_pkg::OFS_ENC_POS: next_rdata = enc_pos;
      homing_pkg::OFS_STATUS:  next_rdata = {26'h0, status};
      homing_pkg::OFS_STATE:   next_rdata = {23'h0, state};
      default:                 mapped = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle so it is stable for the access cycle.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      PRDATA <= 32'h0;
    end
    else if (PSEL && !PENABLE && !PWRITE)
    begin
      PRDATA <= next_rdata;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      home_q <= 1'b0;
      gate_q <= 1'b0;
    end
    else
    begin
      home_q <= home_act;
      gate_q <= gate;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state      <= homing_pkg::S_IDLE;
      dir_search <= 1'b1;
      hunting    <= 1'b0;
    end
    else if (fault_now)
    begin
      state <= homing_pkg::S_IDLE;
    end
    else if (hold_req && busy && state != homing_pkg::S_HOLD)
    begin
      state <= dwelling ? homing_pkg::S_IDLE : homing_pkg::S_HOLD;
    end
    else
    begin
      case (state)
        homing_pkg::S_IDLE:
          if (start_req && ctrl[homing_pkg::CTRL_HOME_CFG])
          begin
            dir_search <= cmd[homing_pkg::CMD_CW];
            hunting    <= 1'b0;
            if (cmd[homing_pkg::CMD_CW] ? lim_cw : lim_ccw)
              state <= homing_pkg::S_RUN2;
            else if (home_act && !ctrl[homing_pkg::CTRL_GATE_EN])
              state <= homing_pkg::S_RUN2;
            else
              state <= homing_pkg::S_RUN1;
          end
        homing_pkg::S_RUN1:
        begin
          if (ctrl[homing_pkg::CTRL_GATE_EN] && gate_rise)
            hunting <= 1'b1;
          if (lim_fwd)
            state <= homing_pkg::S_DWELL1;
          else if (finish)
            state <= homing_pkg::S_IDLE;
          else if (!ctrl[homing_pkg::CTRL_GATE_EN] && home_act)
            state <= homing_pkg::S_DEC1;
        end
        homing_pkg::S_DEC1:
          if (lim_fwd)
            state <= homing_pkg::S_DWELL1;
          else if (at_floor)
            state <= homing_pkg::S_DWELL1;
        homing_pkg::S_DWELL1:
          if (dwell_done)
            state <= homing_pkg::S_RUN2;
        homing_pkg::S_RUN2:
          if (!home_act)
            state <= homing_pkg::S_DEC2;
        homing_pkg::S_DEC2:
          if (at_floor)
            state <= homing_pkg::S_DWELL2;
        homing_pkg::S_DWELL2:
          if (dwell_done)
            state <= homing_pkg::S_CREEP;
        homing_pkg::S_CREEP:
          if (finish)
            state <= homing_pkg::S_IDLE;
        homing_pkg::S_HOLD:
          if (at_floor)
            state <= homing_pkg::S_IDLE;
        default:
          state <= homing_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      dwell_cnt <= 32'h0;
    else if (dwelling && !dwell_done)
      dwell_cnt <= dwell_cnt + 32'h1;
    else
      dwell_cnt <= 32'h0;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      tick_cnt <= 32'h0;
      tick     <= 1'b0;
    end
    else
    begin
      tick     <= tick_cnt == RAMP_TICK_CYCLES - 1;
      tick_cnt <= (tick_cnt == RAMP_TICK_CYCLES - 1) ? 32'h0 : tick_cnt + 32'h1;
    end
  end

  // A gated hunt and every slow phase aim at the start speed, which is also the floor.
  always_comb
  begin
    target = start_speed;
    if ((state == homing_pkg::S_RUN1 && !hunting) || state == homing_pkg::S_RUN2)
      target = (prog_speed > start_speed) ? prog_speed : start_speed;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      cur_speed <= '0;
    else if (!moving)
      cur_speed <= '0;
    else if (cur_speed == '0)
      cur_speed <= start_speed;
    else if (tick)
      cur_speed <= ramp(cur_speed, target, accel);
  end

  assign acc_sum = step_acc + {8'h0, cur_speed};

  // Phase accumulator: one step each time CLK_HZ worth of speed has built up.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      step_acc <= 32'h0;
      STEP_OUT <= 1'b0;
    end
    else if (!moving)
    begin
      step_acc <= 32'h0;
      STEP_OUT <= 1'b0;
    end
    else if (acc_sum >= homing_pkg::CLK_HZ)
    begin
      step_acc <= acc_sum - homing_pkg::CLK_HZ;
      STEP_OUT <= 1'b1;
    end
    else
    begin
      step_acc <= acc_sum;
      STEP_OUT <= 1'b0;
    end
  end

  // Direction is frozen during a hold so the ramp-down keeps its heading.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      DIR_CW <= 1'b1;
    else if (state != homing_pkg::S_HOLD)
      DIR_CW <= (state inside {homing_pkg::S_RUN2, homing_pkg::S_DEC2})
                ? ~dir_search : dir_search;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      motor_pos <= '0;
    else if (finish)
      motor_pos <= '0;
    else if (pre_mot_ok)
      motor_pos <= pre_mot;
    else if (pre_fenc_ok)
      motor_pos <= scaled[31:0];
    else if (STEP_OUT)
      motor_pos <= DIR_CW ? motor_pos + 32'sd1 : motor_pos - 32'sd1;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      enc_pos <= '0;
    else if (finish && ctrl[homing_pkg::CTRL_ENC_EN])
      enc_pos <= '0;
    else if (pre_enc_ok)
      enc_pos <= pre_enc;
    else if (ctrl[homing_pkg::CTRL_ENC_EN] && (ENC_UP != ENC_DOWN))
      enc_pos <= ENC_UP ? enc_pos + 32'sd1 : enc_pos - 32'sd1;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      MOVE_GO       <= 1'b0;
      MOVE_ABSOLUTE <= 1'b0;
    end
    else
    begin
      MOVE_GO <= ~busy & (cmd[homing_pkg::CMD_MOVE_REL] |
                          (cmd[homing_pkg::CMD_MOVE_ABS] & status[homing_pkg::ST_HOMED]));
      if (~busy & (cmd[homing_pkg::CMD_MOVE_REL] | cmd[homing_pkg::CMD_MOVE_ABS]))
        MOVE_ABSOLUTE <= ~cmd[homing_pkg::CMD_MOVE_REL];
    end
  end

  // Sticky flags: a setting event in the clearing cycle wins.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      status <= 6'h00;
    else
    begin
      status[homing_pkg::ST_BUSY] <= busy;
      if (finish | pre_mot_ok | pre_fenc_ok)
        status[homing_pkg::ST_HOMED] <= 1'b1;
      if (fault_now)
        status[homing_pkg::ST_INVALID] <= 1'b1;
      else if (cmd[homing_pkg::CMD_CLEAR])
        status[homing_pkg::ST_INVALID] <= 1'b0;
      if (start_req && !busy && !ctrl[homing_pkg::CTRL_HOME_CFG])
        status[homing_pkg::ST_NO_HOME] <= 1'b1;
      else if (cmd[homing_pkg::CMD_CLEAR])
        status[homing_pkg::ST_NO_HOME] <= 1'b0;
      if (pre_refused)
        status[homing_pkg::ST_PRE_ERR] <= 1'b1;
      else if (cmd[homing_pkg::CMD_CLEAR])
        status[homing_pkg::ST_PRE_ERR] <= 1'b0;
      if (!busy && cmd[homing_pkg::CMD_MOVE_ABS] && !status[homing_pkg::ST_HOMED])
        status[homing_pkg::ST_ABS_REF] <= 1'b1;
      else if (cmd[homing_pkg::CMD_CLEAR])
        status[homing_pkg::ST_ABS_REF] <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [sim/homing_monitor.sv]
// Concurrent checks on the ports of the homing sequencer.
`default_nettype none
module homing_monitor (
  input wire logic        CLK,
  input wire logic        ARST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        HOME_IN,
  input wire logic        LIMIT_CW_IN,
  input wire logic        LIMIT_CCW_IN,
  input wire logic        ENC_UP,
  input wire logic        ENC_DOWN,
  input wire logic        STEP_OUT,
  input wire logic        DIR_CW,
  input wire logic        MOVE_GO,
  input wire logic        MOVE_ABSOLUTE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  logic acc;
  logic cmd_w;
  assign acc = PSEL && PENABLE;
  assign cmd_w = acc && PWRITE && PADDR == homing_pkg::OFS_CMD;
  AST_UNMAPPED: assert property (acc && PADDR > 8'h34 |-> PSLVERR && (PWRITE || PRDATA == 0))
    else $error("unmapped access not refused");
  AST_CMD_READ: assert property (acc && !PWRITE && PADDR == homing_pkg::OFS_CMD |-> PRDATA == 0)
    else $error("command register read not zero");
  AST_STATE_ONEHOT: assert property (acc && !PWRITE && PADDR == homing_pkg::OFS_STATE
    |-> $onehot(PRDATA[8:0]) && PRDATA[31:9] == 0) else $error("state not one-hot");
  AST_STEP_PULSE: assert property (STEP_OUT |=> !STEP_OUT)
    else $error("step pulse longer than a cycle");
  AST_DIR_SETTLED: assert property (STEP_OUT |-> $stable(DIR_CW))
    else $error("direction changed with a step");
  AST_GO_PULSE: assert property ($rose(MOVE_GO) |=> $fell(MOVE_GO))
    else $error("move pulse longer than a cycle");
  AST_REL_GO: assert property (cmd_w && PWDATA == 32'h80 |=> MOVE_GO && !MOVE_ABSOLUTE)
    else $error("relative move not accepted");
  AST_CW_FIRST: assert property (cmd_w && PWDATA == 32'h1 && !HOME_IN && !LIMIT_CW_IN
    |-> ##2 DIR_CW) else $error("clockwise search not clockwise");
  AST_CCW_FIRST: assert property (cmd_w && PWDATA == 32'h2 && !HOME_IN && !LIMIT_CCW_IN
    |-> ##2 !DIR_CW) else $error("counter-clockwise search wrong way");
  cover property (cmd_w && PWDATA == 32'h1);
  cover property (MOVE_GO);
  cover property (STEP_OUT && !DIR_CW);
endmodule
bind stepper_homing_sequencer homing_monitor mon (.CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .HOME_IN, .LIMIT_CW_IN, .LIMIT_CCW_IN,
  .ENC_UP, .ENC_DOWN, .STEP_OUT, .DIR_CW, .MOVE_GO, .MOVE_ABSOLUTE);
`default_nettype wire

// [sim/axis_model.sv]
// Behavioural axis: shaft position, periodic home sensor and encoder pulses.
`default_nettype none
module axis_model (
  input  wire logic clk,
  input  wire logic step,
  input  wire logic dir_cw,
  output var  logic home,
  output var  logic enc_up = 1'b0,
  output var  logic enc_down = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  int pos = 0;
  // The sensor repeats every 100 steps so a gated search meets it more than once.
  assign home = (pos % 100) >= 20 && (pos % 100) <= 40;
  always @(posedge clk)
  begin
    if (step)
      pos <= dir_cw ? pos + 1 : pos - 1;
    enc_up <= step && dir_cw;
    enc_down <= step && !dir_cw;
  end
endmodule
`default_nettype wire

// [sim/stepper_homing_sequencer_bench.sv]
// Self-checking bench for the stepper homing sequencer.
`default_nettype none
module stepper_homing_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLK = 1'b0;
  logic        ARST_N = 1'b0;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic        LIMIT_CW_IN = 1'b0;
  logic        LIMIT_CCW_IN = 1'b0;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        HOME_IN;
  logic        ENC_UP;
  logic        ENC_DOWN;
  logic        STEP_OUT;
  logic        DIR_CW;
  logic        MOVE_GO;
  logic        MOVE_ABSOLUTE;
  logic [31:0] d;
  logic        slverr;
  int          failures = 0;
  int          num_checks = 0;
  int          cyc = 0;
  stepper_homing_sequencer #(.RAMP_TICK_CYCLES(4), .DWELL_CYCLES(50)) DUT (.CLK, .ARST_N,
    .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .HOME_IN,
    .LIMIT_CW_IN, .LIMIT_CCW_IN, .ENC_UP, .ENC_DOWN, .STEP_OUT, .DIR_CW, .MOVE_GO,
    .MOVE_ABSOLUTE);
  axis_model axis (.clk(CLK), .step(STEP_OUT), .dir_cw(DIR_CW), .home(HOME_IN),
    .enc_up(ENC_UP), .enc_down(ENC_DOWN));
  initial
  begin
    forever #10 CLK = ~CLK;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      failures++;
      wrap_up;
    end
  end
  // An idle cycle precedes each transfer so a strobe is never dropped and raised in one step.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= v;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    d = PRDATA;
    slverr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(d & m, e);
  endtask
  task automatic idle;
    do xfer(1'b0, homing_pkg::OFS_STATE, 32'h0); while (d[8:0] !== 9'h001);
  endtask
  task automatic wait_step;
    do @(posedge CLK); while (STEP_OUT !== 1'b1);
  endtask
  initial
  begin
    repeat (16) @(posedge CLK);
    ARST_N <= 1'b1;
    rchk(homing_pkg::OFS_CTRL, 32'hffffffff, 32'h0);
    rchk(homing_pkg::OFS_START, 32'hffffffff, 32'(homing_pkg::START_RESET));
    chk(32'(slverr), 32'h0);
    rchk(8'h40, 32'hffffffff, 32'h0);
    chk(32'(slverr), 32'h1);
    xfer(1'b1, homing_pkg::OFS_CMD, 32'h1);
    rchk(homing_pkg::OFS_STATUS, 32'h8, 32'h8);
    xfer(1'b1, homing_pkg::OFS_CMD, 32'h80);
    // The move outputs are launched at the access edge, so look once they have settled.
    @(negedge CLK);
    chk(32'(MOVE_GO), 32'h1);
    chk(32'(MOVE_ABSOLUTE), 32'h0);
    xfer(1'b1, homing_pkg::OFS_CMD, 32'h40);
    rchk(homing_pkg::OFS_STATUS, 32'h20, 32'h20);
    $display("test refusals done");
    xfer(1'b1, homing_pkg::OFS_PRE_MOT, 32'h00800000);
    xfer(1'b1, homing_pkg::OFS_CMD, 32'h8);
    rchk(homing_pkg::OFS_STATUS, 32'h10, 32'h10);
    xfer(1'b1, homing_pkg::OFS_PRE_MOT, 32'hff800001);
    xfer(1'b1, homing_pkg::OFS_CMD, 32'h8);
    rchk(homing_pkg::OFS_MOT_POS, 32'hffffffff, 32'hff800001);
    xfer(1'b1, homing_pkg::OFS_PRE_ENC, 32'h1000);
    xfer(1'b1, homing_pkg::OFS_STEPS, 32'h7d0);
    xfer(1'b1, homing_pkg::OFS_CMD, 32'h10);
    xfer(1'b1, homing_pkg::OFS_CMD, 32'h20);
    rchk(homing_pkg::OFS_MOT_POS, 32'hffffffff, 32'h7d0);
    xfer(1'b1, homing_pkg::OFS_CMD, 32'h100);
    rchk(homing_pkg::OFS_STATUS, 32'h3c, 32'h0);
    $display("test presets done");
    xfer(1'b1, homing_pkg::OFS_START, 32'd1000000);
    xfer(1'b1, homing_pkg::OFS_PROG, 32'd2500000);
    xfer(1'b1, homing_pkg::OFS_ACCEL, 32'd500000);
    xfer(1'b1, homing_pkg::OFS_CTRL, 32'h12);
    xfer(1'b1, homing_pkg::OFS_CMD, 32'h1);
    idle;
    chk(32'(axis.pos), 32'd20);
    rchk(homing_pkg::OFS_MOT_POS, 32'hffffffff, 32'h0);
    rchk(homing_pkg::OFS_ENC_POS, 32'hffffffff, 32'h0);
    xfer(1'b1, homing_pkg::OFS_CMD, 32'h40);
    rchk(homing_pkg::OFS_STATUS, 32'h22, 32'h2);
    chk(32'(MOVE_ABSOLUTE), 32'h1);
    $display("test sensor-only search done");
    xfer(1'b1, homing_pkg::OFS_CMD, 32'h1);
    wait_step;
    chk(32'(DIR_CW), 32'h0);
    xfer(1'b1, homing_pkg::OFS_CMD, 32'h4);
    rchk(homing_pkg::OFS_STATE, 32'hffffffff, 32'h100);
    idle;
    repeat (200) @(posedge CLK);
    rchk(homing_pkg::OFS_STATE, 32'hffffffff, 32'h1);
    $display("test hold done");
    xfer(1'b1, homing_pkg::OFS_CTRL, 32'h1e);
    xfer(1'b1, homing_pkg::OFS_CMD, 32'h2);
    wait_step;
    LIMIT_CW_IN <= 1'b1;
    idle;
    rchk(homing_pkg::OFS_STATUS, 32'h4, 32'h4);
    LIMIT_CW_IN <= 1'b0;
    xfer(1'b1, homing_pkg::OFS_CMD, 32'h2);
    wait_step;
    LIMIT_CCW_IN <= 1'b1;
    rchk(homing_pkg::OFS_STATE, 32'hffffffff, 32'h8);
    xfer(1'b1, homing_pkg::OFS_CMD, 32'h4);
    LIMIT_CCW_IN <= 1'b0;
    idle;
    $display("test opposite limit done");
    xfer(1'b1, homing_pkg::OFS_CTRL, 32'h13);
    xfer(1'b1, homing_pkg::OFS_CMD, 32'h1);
    wait (axis.pos > 45);
    xfer(1'b1, homing_pkg::OFS_GATE, 32'h1);
    xfer(1'b1, homing_pkg::OFS_GATE, 32'h0);
    idle;
    chk(32'(axis.pos), 32'd120);
    $display("test gated search done");
    wrap_up;
  end
endmodule
`default_nettype wire
